// [verilog/adcsc_pkg.sv]
// Constants, types and helpers shared by the converter control files
package adcsc_pkg;

  // Register byte addresses
  localparam logic [7:0] OFF_CTRL0     = 8'h00;
  localparam logic [7:0] OFF_CTRL1     = 8'h04;
  localparam logic [7:0] OFF_CTRL2     = 8'h08;
  localparam logic [7:0] OFF_RES_HIGH  = 8'h0C;
  localparam logic [7:0] OFF_RES_LOW   = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;

  // Field positions
  localparam int CTRL0_EN_BIT  = 0;
  localparam int CTRL0_GO_BIT  = 1;
  localparam int CTRL0_CHS_LSB = 2;
  localparam int CTRL0_CAL_BIT = 7;
  localparam int CTRL1_PIN_ANALOG_CONFIG_LSB = 0;
  localparam int CTRL1_PREF_BIT = 4;
  localparam int CTRL1_NREF_BIT = 5;
  localparam int CTRL2_CONV_CLOCK_SELECT_LSB = 0;
  localparam int CTRL2_ACQUIRE_TIME_SELECT_LSB = 3;
  localparam int CTRL2_FMT_BIT  = 7;
  localparam int STATUS_DONE_BIT = 0;

  // Values after reset
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;

  // Sizes and counts
  localparam int NUM_CHAN = 12;
  localparam int RES_BITS = 10;
  localparam logic [4:0] CONV_LAST_CNT = 5'h0A;
  localparam logic [3:0] PIN_ANALOG_CONFIG_FIRST_DIG = 4'h4;
  localparam logic [3:0] CHS_FIRST_BAD  = 4'hC;

  // Timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int INSTR_CYCLE_NS = 160;
  localparam int RC_DELAY_CLKS  =
    (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RCWAIT = 2'b01,
    ST_ACQ    = 2'b10,
    ST_CONV   = 2'b11
  } adcsc_state_type;

  // Acquisition length in conversion clock periods
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0:    acq_tads = 5'h00;
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0C;
      3'h6:    acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  // Oscillator divide ratio; codes x11 pick the RC clock instead
  function automatic logic [6:0] clk_div(input logic [2:0] code);
    case (code)
      3'h0:    clk_div = 7'h02;
      3'h1:    clk_div = 7'h08;
      3'h2:    clk_div = 7'h20;
      3'h4:    clk_div = 7'h04;
      3'h5:    clk_div = 7'h10;
      3'h6:    clk_div = 7'h40;
      default: clk_div = 7'h02;
    endcase
  endfunction

endpackage

// [verilog/adcsc_tad_if.sv]
// Conversion clock tick link between control and clock generator
`timescale 1ns/1ns
`default_nettype none
interface adcsc_tad_if;
  logic       run;
  logic [2:0] clk_sel;
  logic       sleep;
  logic       tick;
  modport gen (input run, input clk_sel, input sleep, output tick);
  modport ctl (output run, output clk_sel, output sleep, input tick);
endinterface
`default_nettype wire

// [verilog/adcsc_tad_gen.sv]
// Conversion clock tick generator: oscillator divider or RC pin
`timescale 1ns/1ns
`default_nettype none
module adcsc_tad_gen
  import adcsc_pkg::*;
(
  input  wire logic  clk,     // System clock
  input  wire logic  rst_n,   // Async reset
  input  wire logic  rc_clk,  // Internal RC oscillator
  adcsc_tad_if.gen   tad      // Tick link
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       rc_s1;
    logic       rc_s2;
    logic       rc_s3;
    logic       rc_lvl;
  } adcsc_gen_st_type;

  adcsc_gen_st_type s_r;
  adcsc_gen_st_type s_nxt;
  logic             tick_c;
  logic             rc_rise;

  always_comb
  begin
    s_nxt       = s_r;
    tick_c      = 1'b0;
    s_nxt.rc_s1 = rc_clk;
    s_nxt.rc_s2 = s_r.rc_s1;
    s_nxt.rc_s3 = s_r.rc_s2;
    // Level counts only once second and third stage agree
    rc_rise = (s_r.rc_s2 == s_r.rc_s3) & s_r.rc_s3 & ~s_r.rc_lvl;
    if (s_r.rc_s2 == s_r.rc_s3)
      s_nxt.rc_lvl = s_r.rc_s3;
    if (!tad.run)
      s_nxt.cnt = 7'h00;
    else if (tad.clk_sel[1:0] == 2'b11)
      tick_c = rc_rise;
    else if (!tad.sleep)
    begin
      // Oscillator stops in sleep, so only the RC source keeps going
      if (s_r.cnt == clk_div(tad.clk_sel) - 7'h01)
      begin
        tick_c    = 1'b1;
        s_nxt.cnt = 7'h00;
      end
      else
        s_nxt.cnt = s_r.cnt + 7'h01;
    end
  end

  assign tad.tick = tick_c;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule
`default_nettype wire

// [verilog/adcsc_top.sv]
// Successive approximation converter control with APB registers
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module adcsc_top
  import adcsc_pkg::*;
(
  input  wire logic                clk,              // 25 MHz clock
  input  wire logic                rst_n,            // Async reset
  input  wire logic                psel,             // APB select
  input  wire logic                penable,          // APB enable
  input  wire logic                pwrite,           // APB write
  input  wire logic [7:0]          paddr,            // APB address
  input  wire logic [31:0]         pwdata,           // APB write data
  output logic      [31:0]         prdata,           // APB read data
  output logic                     pready,           // APB ready
  output logic                     pslverr,          // APB error
  input  wire logic                sleep,            // Device asleep
  input  wire logic                rc_clk,           // RC oscillator
  input  wire logic                comp_in,          // Comparator out
  output logic      [NUM_CHAN-1:0] chan_route,       // Mux one-hot
  output logic                     chan_valid,       // Channel code ok
  output logic      [NUM_CHAN-1:0] pin_analog,       // 1 = analog pin
  output logic                     vref_neg_ext,     // Ext neg ref
  output logic                     vref_pos_ext,     // Ext pos ref
  output logic                     sample_en,        // Hold cap tracks
  output logic      [RES_BITS-1:0] dac_code,         // Trial code
  output logic                     calibrate_active, // Offset cal
  output logic                     conv_done_flag    // Done flag
);

  typedef struct packed {
    adcsc_state_type       state;
    logic                  en;
    logic                  cal;
    logic [3:0]            channel_select;
    logic                  nref;
    logic                  pref;
    logic [3:0]            pin_analog_config;
    logic                  fmt;
    logic [2:0]            acquire_time_select;
    logic [2:0]            conv_clock_select;
    logic                  flag;
    logic [4:0]            cnt;
    logic [2:0]            dly;
    logic [RES_BITS-1:0]   trial;
    logic [31:0]           prdata;
    logic                  cmp_s1;
    logic                  cmp_s2;
    logic                  cmp_s3;
    logic                  cmp_val;
  } adcsc_st_type;

  adcsc_st_type        s_r;
  adcsc_st_type        s_nxt;
  logic [15:0]         res_r;
  logic [15:0]         res_nxt;
  logic                res_load;
  logic                tick;
  logic                busy;
  logic                mapped;
  logic                acc;
  logic                wr;
  logic                done_set;
  logic                done_clr;
  logic                start;
  logic                wr_ctrl0;
  logic [RES_BITS-1:0] mask;
  logic [RES_BITS-1:0] final_code;
  logic [4:0]          cnt_inc;

  adcsc_tad_if tad ();

  adcsc_tad_gen u_tad (
    .clk    (clk),
    .rst_n  (rst_n),
    .rc_clk (rc_clk),
    .tad    (tad)
  );

  assign tick = tad.tick;
  assign busy = (s_r.state != ST_IDLE);

  // Zero-wait slave: every access completes in its first access cycle
  assign mapped = (paddr == OFF_CTRL0) || (paddr == OFF_CTRL1) ||
                  (paddr == OFF_CTRL2) || (paddr == OFF_RES_HIGH) ||
                  (paddr == OFF_RES_LOW) || (paddr == OFF_STATUS);
  assign acc      = psel & penable;
  assign wr       = acc & pwrite & mapped;
  assign wr_ctrl0 = wr & (paddr == OFF_CTRL0);
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign prdata   = s_r.prdata;

  assign tad.run     = (s_r.state == ST_ACQ) || (s_r.state == ST_CONV);
  assign tad.clk_sel = s_r.conv_clock_select;
  assign tad.sleep   = sleep;

  always_comb
  begin
    s_nxt      = s_r;
    res_load   = 1'b0;
    done_set   = 1'b0;
    done_clr   = 1'b0;
    start      = 1'b0;
    mask       = '0;
    final_code = '0;
    cnt_inc    = s_r.cnt + 5'h01;

    s_nxt.cmp_s1 = comp_in;
    s_nxt.cmp_s2 = s_r.cmp_s1;
    s_nxt.cmp_s3 = s_r.cmp_s2;
    if (s_r.cmp_s2 == s_r.cmp_s3)
      s_nxt.cmp_val = s_r.cmp_s3;

    case (s_r.state)
      ST_IDLE:
      begin
        s_nxt.cnt = 5'h00;
        s_nxt.dly = 3'h0;
      end
      ST_RCWAIT:
      begin
        // Lets the processor enter sleep before the RC clock runs
        if (s_r.dly == 3'(RC_DELAY_CLKS - 1))
          s_nxt.state = (acq_tads(s_r.acquire_time_select) == 5'h00) ? ST_CONV : ST_ACQ;
        else
          s_nxt.dly = s_r.dly + 3'h1;
      end
      ST_ACQ:
      begin
        if (tick)
        begin
          if (cnt_inc == acq_tads(s_r.acquire_time_select))
          begin
            s_nxt.state = ST_CONV;
            s_nxt.cnt   = 5'h00;
          end
          else
            s_nxt.cnt = cnt_inc;
        end
      end
      ST_CONV:
      begin
        if (tick)
        begin
          if (s_r.cnt == 5'h00)
            s_nxt.trial = RES_BITS'(1) << (RES_BITS - 1);
          else
          begin
            // Comparator low means the trial bit overshoots
            mask = RES_BITS'(1) << (5'(RES_BITS) - s_r.cnt);
            final_code = s_r.cmp_val ? s_r.trial : (s_r.trial & ~mask);
            s_nxt.trial = final_code | (mask >> 1);
          end
          if (s_r.cnt == CONV_LAST_CNT)
          begin
            s_nxt.trial = final_code;
            s_nxt.state = ST_IDLE;
            s_nxt.cnt   = 5'h00;
            res_load    = 1'b1;
            done_set    = 1'b1;
          end
          else
            s_nxt.cnt = cnt_inc;
        end
      end
      default:
        s_nxt.state = ST_IDLE;
    endcase

    if (wr)
    begin
      case (paddr)
        OFF_CTRL0:
        begin
          s_nxt.cal = pwdata[CTRL0_CAL_BIT];
          s_nxt.channel_select = pwdata[CTRL0_CHS_LSB +: 4];
          s_nxt.en  = pwdata[CTRL0_EN_BIT];
          // Writing go as 0 while busy is ignored, it does not abort
          start = pwdata[CTRL0_GO_BIT] & pwdata[CTRL0_EN_BIT] & ~busy;
        end
        OFF_CTRL1:
        begin
          s_nxt.pin_analog_config = pwdata[CTRL1_PIN_ANALOG_CONFIG_LSB +: 4];
          s_nxt.pref = pwdata[CTRL1_PREF_BIT];
          s_nxt.nref = pwdata[CTRL1_NREF_BIT];
        end
        OFF_CTRL2:
        begin
          s_nxt.conv_clock_select = pwdata[CTRL2_CONV_CLOCK_SELECT_LSB +: 3];
          s_nxt.acquire_time_select = pwdata[CTRL2_ACQUIRE_TIME_SELECT_LSB +: 3];
          s_nxt.fmt  = pwdata[CTRL2_FMT_BIT];
        end
        OFF_STATUS:
          done_clr = pwdata[STATUS_DONE_BIT];
        default:
          done_clr = 1'b0;
      endcase
    end

    if (start)
    begin
      s_nxt.cnt = 5'h00;
      s_nxt.dly = 3'h0;
      if (s_r.conv_clock_select[1:0] == 2'b11)
        s_nxt.state = ST_RCWAIT;
      else if (acq_tads(s_r.acquire_time_select) == 5'h00)
        s_nxt.state = ST_CONV;
      else
        s_nxt.state = ST_ACQ;
    end

    // Disable aborts whatever is in flight
    if (!s_nxt.en)
      s_nxt.state = ST_IDLE;

    // A completion in the clearing cycle keeps the flag set
    s_nxt.flag = (s_r.flag & ~done_clr) | done_set;

    // Read data captured in the setup cycle
    if (psel && !penable)
    begin
      case (paddr)
        OFF_CTRL0:
          s_nxt.prdata = {24'h000000, s_r.cal, 1'b0, s_r.channel_select,
                          busy, s_r.en};
        OFF_CTRL1:
          s_nxt.prdata = {24'h000000, 2'b00, s_r.nref,
                          s_r.pref, s_r.pin_analog_config};
        OFF_CTRL2:
          s_nxt.prdata = {24'h000000, s_r.fmt, 1'b0,
                          s_r.acquire_time_select, s_r.conv_clock_select};
        OFF_RES_HIGH:
          s_nxt.prdata = {24'h000000, res_r[15:8]};
        OFF_RES_LOW:
          s_nxt.prdata = {24'h000000, res_r[7:0]};
        OFF_STATUS:
          s_nxt.prdata = {31'h00000000, s_r.flag};
        default:
          s_nxt.prdata = 32'h00000000;
      endcase
    end
  end

  assign res_nxt = s_r.fmt ? {6'h00, final_code}
                           : {final_code, 6'h00};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r       <= '0;
      s_r.state <= ST_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // Result pair survives reset by design
  always_ff @(posedge clk)
  begin
    if (res_load)
      res_r <= res_nxt;
  end

  generate
    for (genvar i = 0; i < NUM_CHAN; i++)
    begin : g_pin
      assign chan_route[i] = s_r.en && (s_r.channel_select == 4'(i));
      assign pin_analog[i] = (s_r.pin_analog_config < PIN_ANALOG_CONFIG_FIRST_DIG) ||
                             (5'(i) + 5'(s_r.pin_analog_config) <= 5'h0E);
    end
  endgenerate

  assign chan_valid       = (s_r.channel_select < CHS_FIRST_BAD);
  assign vref_neg_ext     = s_r.nref;
  assign vref_pos_ext     = s_r.pref;
  assign sample_en        = s_r.en && (s_r.state != ST_CONV);
  assign dac_code         = s_r.trial;
  assign calibrate_active = s_r.cal && (s_r.state == ST_CONV);
  assign conv_done_flag   = s_r.flag;

  // Checking helper: ticks seen in the current phase
  logic [4:0] h_ticks_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      h_ticks_r <= 5'h00;
    else if (s_nxt.state != s_r.state)
      h_ticks_r <= 5'h00;
    else if (tick)
      h_ticks_r <= h_ticks_r + 5'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_done;
    s_r.state == ST_CONV && tick && s_r.cnt == CONV_LAST_CNT;
  endsequence
  sequence s_start_rc;
    start && s_r.conv_clock_select[1:0] == 2'b11 && s_nxt.en;
  endsequence
  sequence s_acq_exit;
    s_r.state == ST_ACQ ##1 s_r.state == ST_CONV;
  endsequence

  chk_done_update: assert property (s_done |=>
    !busy && s_r.flag && s_r.trial == $past(final_code))
    else $error("completion did not clear busy or set flag");
  chk_conv_length: assert property (s_done |->
    h_ticks_r == 5'h0A)
    else $error("conversion did not last eleven periods");
  chk_acq_length: assert property (s_acq_exit |->
    $past(h_ticks_r) == acq_tads(s_r.acquire_time_select) - 5'h01)
    else $error("acquisition length wrong");
  chk_rc_delay: assert property (s_start_rc |=>
    (s_r.state == ST_RCWAIT)[*4] ##1 s_r.state != ST_RCWAIT)
    else $error("rc start delay not four clocks");
  chk_disable_abort: assert property (wr_ctrl0 &&
    !pwdata[CTRL0_EN_BIT] |=> !busy && !sample_en)
    else $error("disable did not abort");
  chk_status_read: assert property (psel && !penable &&
    paddr == OFF_CTRL0 |=> prdata[1] == $past(busy) &&
    prdata[6] == 1'b0)
    else $error("status bit read wrong");
  chk_chan_route: assert property (s_r.en |->
    (chan_valid ? $onehot(chan_route) : chan_route == '0))
    else $error("channel routing wrong");
  chk_pin_count: assert property (s_r.pin_analog_config >= PIN_ANALOG_CONFIG_FIRST_DIG |->
    $countones(pin_analog) == 15 - int'(s_r.pin_analog_config))
    else $error("analog pin count wrong");
  chk_justify: assert property (s_done ##1 $stable(s_r.fmt) |->
    (s_r.fmt ? res_r[15:10] == 6'h00 : res_r[5:0] == 6'h00))
    else $error("result justification wrong");
  chk_flag_sticky: assert property ((s_done and (wr &&
    paddr == OFF_STATUS)) |=> s_r.flag)
    else $error("clear beat completion");
  chk_sample_resume: assert property ((s_done and s_r.en) ##1
    s_r.en |-> sample_en)
    else $error("sampling not resumed");

endmodule
`default_nettype wire

// [dv/adcsc_analog_model.sv]
// Analog input mux, sample-and-hold and comparator model
`timescale 1ns/1ns
`default_nettype none
module adcsc_analog_model
  import adcsc_pkg::*;
(
  input  wire logic                         clk,        // System clock
  input  wire logic [NUM_CHAN*RES_BITS-1:0] levels,     // Pin levels
  input  wire logic [NUM_CHAN-1:0]          chan_route, // Mux select
  input  wire logic                         sample_en,  // Cap tracks
  input  wire logic [RES_BITS-1:0]          dac_code,   // Trial code
  output logic                              comp_out    // Input >= trial
);
  logic [RES_BITS-1:0] held_r;
  logic [RES_BITS-1:0] pick;

  always_comb
  begin
    // Open mux floats, so never echo the last level
    pick = ~held_r;
    for (int i = 0; i < NUM_CHAN; i++)
      if (chan_route[i])
        pick = levels[i*RES_BITS +: RES_BITS];
  end

  // Cap keeps its charge once sampling stops
  always @(posedge clk)
    if (sample_en)
      held_r <= pick;

  assign comp_out = (held_r >= dac_code);
endmodule
`default_nettype wire

// [dv/adcsc_top_bench.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcsc_top_bench
  import adcsc_pkg::*;
;
  localparam int RC_P = 24;
  logic                         clk, rst_n, psel, penable, pwrite;
  logic                         sleep, rc_clk, comp_in, pready, pslverr;
  logic                         chan_valid, vref_neg_ext, vref_pos_ext;
  logic                         sample_en, calibrate_active, conv_done_flag;
  logic [7:0]                   paddr, last_hi, last_lo;
  logic [31:0]                  pwdata, prdata;
  logic [NUM_CHAN-1:0]          chan_route, pin_analog;
  logic [RES_BITS-1:0]          dac_code;
  logic [NUM_CHAN*RES_BITS-1:0] levels;
  logic [32:0]                  exp_q[$];
  logic [2:0]                   cs_tab[8] = '{3'h1, 3'h2, 3'h3, 3'h5,
                                              3'h6, 3'h7, 3'h3, 3'h1};
  int                           acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int                           err_count, total_checks;

  adcsc_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .rc_clk(rc_clk), .comp_in(comp_in), .chan_route(chan_route),
    .chan_valid(chan_valid), .pin_analog(pin_analog),
    .vref_neg_ext(vref_neg_ext), .vref_pos_ext(vref_pos_ext),
    .sample_en(sample_en), .dac_code(dac_code),
    .calibrate_active(calibrate_active), .conv_done_flag(conv_done_flag));

  adcsc_analog_model model_u (.clk(clk), .levels(levels),
    .chan_route(chan_route), .sample_en(sample_en), .dac_code(dac_code),
    .comp_out(comp_in));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Phase unrelated to clk on purpose
  initial
  begin
    rc_clk = 1'b0;
    #7;
    forever #487 rc_clk = ~rc_clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tally(input logic ok, input logic [32:0] g, e);
    total_checks++;
    if (!ok)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp_read(input logic [32:0] g, e);
    tally(g === e, g, e);
  endtask

  task automatic cmp_port(input logic [31:0] g, e);
    tally(g === e, {1'b0, g}, {1'b0, e});
  endtask

  // One APB transfer; an idle cycle follows so psel is never reassigned
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, d, input logic e = 1'b0);
    exp_q.push_back({e, 24'h0, d});
    apb(a, 1'b0, 32'h0);
  endtask

  // Read data taken at the very edge that samples pready high
  always @(posedge clk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      cmp_read({pslverr, prdata}, exp_q.pop_front());

  function automatic int tick_clks(input logic [2:0] s);
    case (s)
      3'h0: return 2;
      3'h1: return 8;
      3'h2: return 32;
      3'h4: return 4;
      3'h5: return 16;
      3'h6: return 64;
      default: return RC_P;
    endcase
  endfunction

  task automatic convert(input logic [2:0] cs, aq, input logic fm, cal,
                         input logic [3:0] ch);
    logic [9:0] v;
    logic       saw_cal;
    int         n, tk, t, lo, hi;
    v = 10'($urandom);
    tk = tick_clks(cs);
    t = (acq_tab[aq] + 11) * tk;
    lo = t - 2;
    hi = t + 4;
    if (cs[1:0] == 2'h3)
    begin
      lo = t + 4 - RC_P;
      hi = t + RC_P + 12;
    end
    saw_cal = 1'b0;
    n = 3;
    levels[ch*RES_BITS +: RES_BITS] <= v;
    sleep <= (cs[1:0] == 2'h3) ? 1'($urandom) : 1'b0;
    wr(OFF_CTRL2, {fm, 1'b0, aq, cs});
    wr(OFF_CTRL0, {cal, 1'b0, ch, 2'b01});
    wr(OFF_CTRL0, {cal, 1'b0, ch, 2'b11});
    rd(OFF_CTRL0, {cal, 1'b0, ch, 2'b11});
    while (conv_done_flag !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
      saw_cal |= (calibrate_active === 1'b1);
    end
    @(negedge clk);
    cmp_port(32'(n >= lo && n <= hi), 32'h1);
    cmp_port(32'(saw_cal), 32'(cal));
    cmp_port(32'(sample_en), 32'h1);
    @(posedge clk);
    sleep <= 1'b0;
    last_hi = fm ? {6'h0, v[9:8]} : v[9:2];
    last_lo = fm ? v[7:0] : {v[1:0], 6'h0};
    rd(OFF_CTRL0, {cal, 1'b0, ch, 2'b01});
    rd(OFF_RES_HIGH, last_hi);
    rd(OFF_RES_LOW, last_lo);
    rd(OFF_STATUS, 8'h01);
    wr(OFF_STATUS, 8'h01);
    rd(OFF_STATUS, 8'h00);
    repeat (2 * tk) @(posedge clk);
  endtask

  // Longest run is well under this
  initial
  begin
    #(60000 * 40);
    err_count++;
    print_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep = 1'b0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(32'h8ABB));
    levels = 120'({$urandom, $urandom, $urandom, $urandom});
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL0, 8'h00);
    rd(OFF_CTRL1, 8'h00);
    rd(OFF_CTRL2, 8'h00);
    cmp_port(32'(pin_analog), 32'hFFF);
    cmp_port(32'(chan_route), 32'h0);
    $display("test reset done");
    wr(OFF_CTRL1, 8'hFF);
    rd(OFF_CTRL1, 8'h3F);
    wr(OFF_CTRL2, 8'hFF);
    rd(OFF_CTRL2, 8'hBF);
    wr(OFF_CTRL0, 8'hFD);
    rd(OFF_CTRL0, 8'hBD);
    rd(8'h18, 8'h00, 1'b1);
    $display("test register bits done");
    for (int c = 0; c < 16; c++)
    begin
      wr(OFF_CTRL0, {2'b00, 4'(c), 2'b01});
      cmp_port(32'(chan_route), c < 12 ? 32'h1 << c : 32'h0);
      cmp_port(32'(chan_valid), 32'(c < 12));
    end
    wr(OFF_CTRL0, 8'h14);
    cmp_port(32'(chan_route), 32'h0);
    for (int p = 0; p < 16; p++)
    begin
      wr(OFF_CTRL1, {2'b00, 2'(p), 4'(p)});
      cmp_port(32'(pin_analog), p < 4 ? 32'hFFF : 32'hFFF >> (p - 3));
      cmp_port(32'({vref_neg_ext, vref_pos_ext}), 32'(p & 3));
    end
    $display("test routing done");
    // Divide by two, no acquisition: done flag lands on the 22nd edge
    wr(OFF_CTRL2, 8'h00);
    wr(OFF_CTRL0, 8'h03);
    repeat (18) @(posedge clk);
    @(negedge clk);
    cmp_port(32'(conv_done_flag), 32'h0);
    @(posedge clk);
    // Clear lands in the completion cycle, so the set must win
    wr(OFF_STATUS, 8'h01);
    cmp_port(32'(conv_done_flag), 32'h1);
    wr(OFF_STATUS, 8'h01);
    rd(OFF_STATUS, 8'h00);
    $display("test fast clock done");
    for (int i = 0; i < 8; i++)
      convert(cs_tab[i], 3'($urandom), 1'($urandom), 1'($urandom),
              4'($urandom_range(11)));
    $display("test conversions done");
    wr(OFF_CTRL2, 8'h04);
    wr(OFF_CTRL0, 8'h03);
    wr(OFF_CTRL0, 8'h00);
    repeat (120) @(posedge clk);
    cmp_port(32'(conv_done_flag), 32'h0);
    rd(OFF_CTRL0, 8'h00);
    $display("test abort done");
    wr(OFF_CTRL2, 8'h86);
    wr(OFF_CTRL0, 8'h03);
    repeat (50) @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL0, 8'h00);
    rd(OFF_CTRL2, 8'h00);
    rd(OFF_STATUS, 8'h00);
    rd(OFF_RES_HIGH, last_hi);
    rd(OFF_RES_LOW, last_lo);
    $display("test mid reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
